// ==== verilog/pss_sram.sv ====
// Access logic of a pipelined synchronous burst SRAM, 256K x 36
`timescale 1ns/1ps
`default_nettype none
module pss_sram (
   input  wire logic                        clk_i,
   input  wire logic                        reset_n_i,
   input  wire logic                        clk_qualify_n_i,
   input  wire logic                        chip_sel_1_n_i,
   input  wire logic                        chip_sel_2_i,
   input  wire logic                        chip_sel_3_n_i,
   input  wire logic                        write_en_n_i,
   input  wire logic                        burst_step_or_load_n_i,
   input  wire logic                        burst_order_i,
   input  wire logic [pss_pkg::LANES-1:0]   byte_lane_sel_n_i,
   input  wire logic [pss_pkg::ADDR_W-1:0]  addr_i,
   input  wire logic                        out_drive_en_n_i,
   input  wire logic                        sleep_req_i,
   input  wire logic [pss_pkg::DATA_W-1:0]  data_i,
   output logic      [pss_pkg::DATA_W-1:0]  data_o,
   output logic                             data_oe_o,
   input  wire logic [pss_pkg::LANES-1:0]   parity_i,
   output logic      [pss_pkg::LANES-1:0]   parity_o,
   output logic                             parity_oe_o,
   output logic                             asleep_o
);

   typedef struct packed {
      logic                          sync1;
      logic                          sync2;
      pss_pkg::pss_slp_t             slp;
      logic [1:0]                    scnt;
      pss_pkg::pss_op_t              s1_op;
      logic [pss_pkg::ADDR_W-1:0]    s1_addr;
      logic [pss_pkg::LANES-1:0]     s1_bws_n;
      pss_pkg::pss_op_t              s2_op;
      logic [pss_pkg::ADDR_W-1:0]    s2_addr;
      logic [pss_pkg::LANES-1:0]     s2_bws_n;
      logic                          burst_on;
      pss_pkg::pss_op_t              dir;
      logic [pss_pkg::BURST_W-1:0]   base;
      logic [pss_pkg::BURST_W-1:0]   bcnt;
      logic                          drv;
      logic [pss_pkg::WORD_W-1:0]    dout;
   } pss_state_t;

   pss_state_t q;
   pss_state_t d;

   // Array has no reset: contents survive reset and sleep alike
   logic [pss_pkg::WORD_W-1:0]  mem_q [0:pss_pkg::DEPTH-1];

   logic                          accept;
   logic                          selected;
   logic                          step;
   logic                          mem_we;
   logic [pss_pkg::WORD_W-1:0]    wr_word;
   logic [pss_pkg::WORD_W-1:0]    rd_word;
   logic [pss_pkg::BURST_W-1:0]   cnt_nxt;
   logic [pss_pkg::BURST_W-1:0]   lo_nxt;

   // Sleep transitions also stop the pipeline, not just sleep itself
   // A pending sleep request wins over a load at the same edge
   assign accept   = !clk_qualify_n_i && !q.sync2
                     && (q.slp == pss_pkg::PSS_SLP_AWAKE);
   assign selected = !chip_sel_1_n_i && chip_sel_2_i && !chip_sel_3_n_i;
   assign step     = burst_step_or_load_n_i;
   assign mem_we   = accept && (q.s2_op == pss_pkg::PSS_OP_WRITE);

   assign cnt_nxt = q.bcnt + 2'h1;
   // Only the two low bits move, so no carry into the upper address
   assign lo_nxt  = burst_order_i ? (q.base ^ cnt_nxt)
                                  : (q.base + cnt_nxt);

   genvar g;
   generate
      for (g = 0; g < pss_pkg::LANES; g++) begin : g_lane
         assign wr_word[g*pss_pkg::LANE_W +: pss_pkg::LANE_W] =
            {parity_i[g], data_i[g*8 +: 8]};
         assign data_o[g*8 +: 8] = q.dout[g*pss_pkg::LANE_W +: 8];
         assign parity_o[g] = q.dout[g*pss_pkg::LANE_W + 8];
         // Forward a write landing on the address being read this edge
         assign rd_word[g*pss_pkg::LANE_W +: pss_pkg::LANE_W] =
            (mem_we && (q.s2_addr == q.s1_addr) && !q.s2_bws_n[g])
            ? wr_word[g*pss_pkg::LANE_W +: pss_pkg::LANE_W]
            : mem_q[q.s1_addr][g*pss_pkg::LANE_W +: pss_pkg::LANE_W];
      end
   endgenerate

   // Drive enable is combinational so the pin follows it at once
   assign data_oe_o   = q.drv && !out_drive_en_n_i
                        && (q.slp == pss_pkg::PSS_SLP_AWAKE);
   assign parity_oe_o = data_oe_o;
   assign asleep_o    = (q.slp == pss_pkg::PSS_SLP_ASLEEP);

   always_comb begin
      d = q;
      d.sync1 = sleep_req_i;
      d.sync2 = q.sync1;
      case (q.slp)
         pss_pkg::PSS_SLP_AWAKE: begin
            if (q.sync2) begin
               d.slp      = pss_pkg::PSS_SLP_ENTER;
               d.scnt     = 2'h0;
               // Whatever was in flight is dropped
               d.s1_op    = pss_pkg::PSS_OP_IDLE;
               d.s2_op    = pss_pkg::PSS_OP_IDLE;
               d.drv      = 1'b0;
               d.burst_on = 1'b0;
            end
         end
         pss_pkg::PSS_SLP_ENTER: begin
            d.scnt = q.scnt + 2'h1;
            if (q.scnt == pss_pkg::SLEEP_CNT_LAST) begin
               d.slp = pss_pkg::PSS_SLP_ASLEEP;
            end
         end
         pss_pkg::PSS_SLP_ASLEEP: begin
            if (!q.sync2) begin
               d.slp  = pss_pkg::PSS_SLP_EXIT;
               d.scnt = 2'h0;
            end
         end
         pss_pkg::PSS_SLP_EXIT: begin
            d.scnt = q.scnt + 2'h1;
            if (q.scnt == pss_pkg::SLEEP_CNT_LAST) begin
               d.slp = pss_pkg::PSS_SLP_AWAKE;
            end
         end
         default: begin
            d.slp = pss_pkg::PSS_SLP_AWAKE;
         end
      endcase

      // No accept means every stage holds its value, except where sleep entry above flushes it
      if (accept) begin
         d.s2_op    = q.s1_op;
         d.s2_addr  = q.s1_addr;
         d.s2_bws_n = q.s1_bws_n;
         d.drv      = (q.s1_op == pss_pkg::PSS_OP_READ);
         if (q.s1_op == pss_pkg::PSS_OP_READ) begin
            d.dout = rd_word;
         end
         if (step) begin
            if (q.burst_on) begin
               d.bcnt     = cnt_nxt;
               d.s1_addr  = {q.s1_addr[pss_pkg::ADDR_W-1:2], lo_nxt};
               d.s1_op    = q.dir;
               d.s1_bws_n = byte_lane_sel_n_i;
            end else begin
               d.s1_op = pss_pkg::PSS_OP_IDLE;
            end
         end else if (selected) begin
            // Any accept here may follow a read directly
            d.s1_addr  = addr_i;
            d.s1_bws_n = byte_lane_sel_n_i;
            d.s1_op    = write_en_n_i ? pss_pkg::PSS_OP_READ
                                      : pss_pkg::PSS_OP_WRITE;
            d.dir      = d.s1_op;
            d.base     = addr_i[1:0];
            d.bcnt     = 2'h0;
            d.burst_on = 1'b1;
         end else begin
            d.s1_op    = pss_pkg::PSS_OP_IDLE;
            d.burst_on = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Unselected lanes are skipped, so they keep their old contents
   always_ff @(posedge clk_i) begin
      if (mem_we) begin
         for (int k = 0; k < pss_pkg::LANES; k++) begin
            if (!q.s2_bws_n[k]) begin
               mem_q[q.s2_addr][k*pss_pkg::LANE_W +: pss_pkg::LANE_W] <=
                  wr_word[k*pss_pkg::LANE_W +: pss_pkg::LANE_W];
            end
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence seq_read_start;
      accept && !step && selected && write_en_n_i;
   endsequence

   sequence seq_desel_then_edge;
      accept && !step && !selected ##1 accept;
   endsequence

   sequence seq_burst_beat;
      accept && step && q.burst_on;
   endsequence

   AST_READ_LOAD: assert property (
      seq_read_start |=> q.s1_op == pss_pkg::PSS_OP_READ
                         && q.s1_addr == $past(addr_i))
      else $error("read start not captured");

   AST_WRITE_LOAD: assert property (
      accept && !step && selected && !write_en_n_i |=>
         q.s1_op == pss_pkg::PSS_OP_WRITE
         && q.s1_bws_n == $past(byte_lane_sel_n_i))
      else $error("write start not captured");

   AST_READ_DRIVE: assert property (
      seq_read_start ##1 accept |=> q.drv && q.dout == $past(rd_word))
      else $error("read data not driven next edge");

   AST_WRITE_FLOAT: assert property (
      q.s1_op == pss_pkg::PSS_OP_WRITE && accept |=> !data_oe_o
                                                  && !parity_oe_o)
      else $error("pins driven during write data");

   AST_DESEL_FLOAT: assert property (
      seq_desel_then_edge |=> !data_oe_o)
      else $error("pins driven after deselect");

   AST_STALL_HOLD: assert property (
      clk_qualify_n_i && q.slp == pss_pkg::PSS_SLP_AWAKE && !q.sync2 |=>
         $stable(q.s1_addr) && $stable(q.s2_op) && $stable(q.dout))
      else $error("state moved on a stalled edge");

   AST_LINEAR: assert property (
      seq_burst_beat and !burst_order_i |=>
         q.s1_addr[1:0] == 2'($past(q.base) + $past(q.bcnt) + 2'h1))
      else $error("linear burst address wrong");

   AST_INTERLEAVE: assert property (
      seq_burst_beat and burst_order_i |=>
         q.s1_addr[1:0] == ($past(q.base) ^ 2'($past(q.bcnt) + 2'h1)))
      else $error("interleaved burst address wrong");

   AST_UPPER_KEPT: assert property (
      seq_burst_beat |=> $stable(q.s1_addr[pss_pkg::ADDR_W-1:2]))
      else $error("burst carried into upper address");

   AST_DIR_KEPT: assert property (
      seq_burst_beat |=> q.s1_op == $past(q.dir))
      else $error("burst changed direction");

   AST_IDLE_STEP: assert property (
      accept && step && !q.burst_on |=> q.s1_op == pss_pkg::PSS_OP_IDLE)
      else $error("burst started while deselected");

   AST_SLEEP_ENTRY: assert property (
      q.slp == pss_pkg::PSS_SLP_AWAKE && q.sync2 |=>
         q.slp == pss_pkg::PSS_SLP_ENTER ##2 asleep_o)
      else $error("sleep entry not two cycles");

   AST_SLEEP_FLUSH: assert property (
      q.slp == pss_pkg::PSS_SLP_ENTER |-> q.s1_op == pss_pkg::PSS_OP_IDLE
         && !data_oe_o)
      else $error("access survived sleep entry");

   sequence seq_wake_start;
      q.slp == pss_pkg::PSS_SLP_ASLEEP && !q.sync2;
   endsequence

   AST_SLEEP_EXIT: assert property (
      seq_wake_start |=> q.slp == pss_pkg::PSS_SLP_EXIT
         ##2 q.slp == pss_pkg::PSS_SLP_AWAKE)
      else $error("sleep exit not two cycles");

   AST_ASLEEP_DARK: assert property (
      q.slp != pss_pkg::PSS_SLP_AWAKE |-> !data_oe_o && !mem_we)
      else $error("pins or array active while sleeping");

   AST_BURST_COUNT: assert property (
      seq_burst_beat |=> q.bcnt == 2'($past(q.bcnt) + 2'h1))
      else $error("burst counter did not step");

   AST_WRITE_COMMIT: assert property (
      mem_we && !q.s2_bws_n[0] |=>
         mem_q[$past(q.s2_addr)][pss_pkg::LANE_W-1:0]
         == $past(wr_word[pss_pkg::LANE_W-1:0]))
      else $error("write lane not stored");

   AST_OE_MASK: assert property (
      out_drive_en_n_i |-> !data_oe_o)
      else $error("pins driven with drive enable off");

   AST_READ_OE_ON: assert property (
      q.drv && !out_drive_en_n_i && q.slp == pss_pkg::PSS_SLP_AWAKE
         |-> data_oe_o)
      else $error("read data not on the pins");

   AST_DESEL_BURST: assert property (
      accept && !step && !selected |=> !q.burst_on)
      else $error("burst kept after deselect");

   AST_LOAD_BASE: assert property (
      accept && !step && selected |=> q.base == $past(addr_i[1:0])
         && q.bcnt == 2'h0)
      else $error("burst base not loaded");

   AST_READ_NEXT: assert property (
      seq_read_start ##1 (accept && !step && selected) |=>
         q.s1_addr == $past(addr_i))
      else $error("access after read refused");

   AST_PARITY_PAIR: assert property (
      parity_oe_o == data_oe_o)
      else $error("parity drive differs from data drive");

endmodule // pss_sram
`default_nettype wire

// ==== verilog/pss_pkg.sv ====
// Shared constants and types for the pipelined synchronous SRAM access block
`default_nettype none
package pss_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int WORD_W = LANES * LANE_W;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int BURST_W = 2;
   localparam int CLK_PERIOD_NS = 10;
   // Sleep entry and exit last two clock periods
   localparam int SLEEP_TCYC = 2;
   localparam int SLEEP_TIME_NS = SLEEP_TCYC * CLK_PERIOD_NS;
   localparam int SLEEP_CYC = (SLEEP_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
   localparam logic [1:0] SLEEP_CNT_LAST = 2'(SLEEP_CYC - 1);

   typedef enum logic [1:0] {
      PSS_OP_IDLE  = 2'h0,
      PSS_OP_READ  = 2'h1,
      PSS_OP_WRITE = 2'h2
   } pss_op_t;

   typedef enum logic [1:0] {
      PSS_SLP_AWAKE  = 2'h0,
      PSS_SLP_ENTER  = 2'h1,
      PSS_SLP_ASLEEP = 2'h3,
      PSS_SLP_EXIT   = 2'h2
   } pss_slp_t;
endpackage
`default_nettype wire

// ==== test/pss_ctrl_model.sv ====
// Controller-side model driving the SRAM pins one beat at a time
`timescale 1ns/1ps
`default_nettype none
module pss_ctrl_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] q_i,
   input  wire logic [3:0]  qp_i,
   input  wire logic [1:0]  oe_i,
   output logic             qual_n_o,
   output logic             cs1_n_o,
   output logic             cs2_o,
   output logic             cs3_n_o,
   output logic             wen_n_o,
   output logic             step_o,
   output logic [3:0]       lanes_n_o,
   output logic [17:0]      addr_o,
   output logic [35:0]      wd_o
);
   logic [35:0] s_q;
   logic [35:0] w0;
   logic [35:0] w1;
   logic [1:0]  s_oe;
   logic        v0;
   logic        v1;
   logic        wr;
   initial begin
      {qual_n_o, cs1_n_o, cs2_o, cs3_n_o, wen_n_o, step_o} = 6'h16;
      lanes_n_o = 4'hf;
      addr_o = 18'h0;
      wd_o = 36'h0;
      {v0, v1, wr, w0, w1} = '0;
   end
   task automatic beat(input logic stall, sel, step, wen_n,
                       input logic [17:0] a, input logic [3:0] ln,
                       input logic [35:0] wd);
      @(negedge clk_i);
      s_q = {qp_i, q_i};
      s_oe = oe_i;
      qual_n_o = stall;
      if (!stall) begin
         {cs1_n_o, cs2_o, cs3_n_o} = {!sel, sel, !sel};
         {step_o, wen_n_o, addr_o, lanes_n_o} = {step, wen_n, a, ln};
         // Idle bus toggles so stale data never passes as written data
         wd_o = v1 ? w1 : ~wd_o;
         if (!step)
            wr = sel & !wen_n;
         {w1, v1, w0, v0} = {w0, v0, wd, wr};
      end
   endtask
endmodule // pss_ctrl_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the pipelined SRAM access block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
   n_mismatch++; $display("FAIL %s exp %h got %h", n, e, s); end end
module tb_top;
   logic        clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        oe_n = 1'b0;
   logic        order = 1'b0;
   logic        sleep = 1'b0;
   wire logic   qual_n, cs1_n, cs2, cs3_n, wen_n, step, asleep;
   wire logic [3:0]  lanes_n, qp;
   wire logic [17:0] addr;
   wire logic [35:0] wd;
   wire logic [31:0] q;
   wire logic [1:0]  oe;
   int          n_mismatch = 0;
   int          check_count = 0;
   int          cnt = 0;
   logic [17:0] base = '0;
   logic        brd = 1'b0, bwr = 1'b0, pv0 = 1'b0, pv1 = 1'b0;
   logic [35:0] pe0 = '0, pe1 = '0;
   logic [35:0] mem [bit [17:0]];
   always #5 clk_i = ~clk_i;
   pss_ctrl_model i_pss_ctrl_model (.clk_i(clk_i), .q_i(q), .qp_i(qp),
      .oe_i(oe), .qual_n_o(qual_n), .cs1_n_o(cs1_n), .cs2_o(cs2),
      .cs3_n_o(cs3_n), .wen_n_o(wen_n), .step_o(step),
      .lanes_n_o(lanes_n), .addr_o(addr), .wd_o(wd));
   pss_sram i_pss_sram (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .clk_qualify_n_i(qual_n), .chip_sel_1_n_i(cs1_n),
      .chip_sel_2_i(cs2), .chip_sel_3_n_i(cs3_n), .write_en_n_i(wen_n),
      .burst_step_or_load_n_i(step), .burst_order_i(order),
      .byte_lane_sel_n_i(lanes_n), .addr_i(addr), .out_drive_en_n_i(oe_n),
      .sleep_req_i(sleep), .data_i(wd[31:0]), .data_o(q),
      .data_oe_o(oe[0]), .parity_i(wd[35:32]), .parity_o(qp),
      .parity_oe_o(oe[1]), .asleep_o(asleep));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check();
      `CHK("oe", {2{pv1 & !oe_n}}, i_pss_ctrl_model.s_oe)
      if (pv1) `CHK("rdata", pe1, i_pss_ctrl_model.s_q)
   endtask
   task automatic op(input logic stp, sel, wen, input logic [17:0] a,
                     input logic [3:0] ln, input logic [35:0] d);
      logic [17:0] ea;
      if (!stp) begin
         base = a;
         cnt = 0;
         brd = sel & wen;
         bwr = sel & !wen;
      end else
         cnt++;
      ea = {base[17:2], order ? base[1:0] ^ 2'(cnt) : base[1:0] + 2'(cnt)};
      if (bwr) begin
         if (!mem.exists(ea))
            mem[ea] = 'x;
         for (int k = 0; k < 4; k++)
            if (!ln[k]) begin
               mem[ea][8*k+:8] = d[8*k+:8];
               mem[ea][32+k] = d[32+k];
            end
      end
      i_pss_ctrl_model.beat(1'b0, sel, stp, wen, a, ln, d);
      check();
      {pv1, pe1, pv0} = {pv0, pe0, brd};
      pe0 = brd ? mem[ea] : '0;
   endtask
   task automatic burst(input logic wen, input logic [17:0] a,
                        input logic [35:0] d);
      op(1'b0, 1'b1, wen, a, 4'h0, d);
      for (int i = 1; i < 4; i++)
         op(1'b1, 1'b0, ~wen, ~a, 4'h0, d + 36'(i));
   endtask
   task automatic idle(input int n);
      op(1'b0, 1'b0, 1'b1, '0, '1, '0);
      for (int i = 1; i < n; i++)
         op(1'b1, 1'b0, 1'b0, '1, '1, '0);
   endtask
   task automatic wait_sleep(input logic lvl);
      int t;
      t = 0;
      while (asleep !== lvl && t < 20) begin
         @(negedge clk_i);
         t++;
      end
      `CHK("asleep", lvl, asleep)
      if (asleep !== lvl)
         end_of_test();
   endtask
   initial begin
      repeat (10) @(negedge clk_i);
      reset_n_i = 1'b1;
      `CHK("oe_rst", 2'h0, oe)
      `CHK("asleep_rst", 1'b0, asleep)
      burst(1'b0, 18'h00102, 36'h5_a5a5_0000);
      burst(1'b1, 18'h00100, '0);
      idle(1);
      order = 1'b1;
      burst(1'b1, 18'h00101, '0);
      $display("burst test done");
      op(1'b0, 1'b1, 1'b0, 18'h00101, 4'he, 36'hf_ffff_ffff);
      op(1'b0, 1'b1, 1'b1, 18'h00101, 4'h0, '0);
      op(1'b0, 1'b1, 1'b1, 18'h00103, 4'h0, '0);
      idle(2);
      $display("lane test done");
      oe_n = 1'b1;
      op(1'b0, 1'b1, 1'b1, 18'h00100, 4'h0, '0);
      idle(2);
      oe_n = 1'b0;
      op(1'b0, 1'b1, 1'b1, 18'h00102, 4'h0, '0);
      i_pss_ctrl_model.beat(1'b1, 1'b0, 1'b0, 1'b1, '0, '1, '0);
      check();
      i_pss_ctrl_model.beat(1'b1, 1'b0, 1'b0, 1'b1, '0, '1, '0);
      check();
      idle(3);
      $display("drive and stall test done");
      sleep = 1'b1;
      wait_sleep(1'b1);
      `CHK("oe_sleep", 2'h0, oe)
      sleep = 1'b0;
      wait_sleep(1'b0);
      idle(4);
      op(1'b0, 1'b1, 1'b1, 18'h00101, 4'h0, '0);
      idle(2);
      $display("sleep test done");
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
